/* hdl/piu_consts.vh */
// constants for the peripheral interrupt priority unit: offsets, bits, resets
// included by the unit's design files; definitions only
`ifndef PIU_CONSTS_VH
`define PIU_CONSTS_VH

// apb word offsets (byte addresses)
`define PIU_ADDR_INTCON 8'h00
`define PIU_ADDR_INTCON2 8'h04
`define PIU_ADDR_THIRD_IRQ_CONTROL 8'h08
`define PIU_ADDR_FLAG1 8'h0C
`define PIU_ADDR_FLAG2 8'h10
`define PIU_ADDR_PERIPHERAL_IRQ_ENABLE_1 8'h14
`define PIU_ADDR_PERIPHERAL_IRQ_ENABLE_2 8'h18
`define PIU_ADDR_PERIPHERAL_IRQ_PRIORITY_1 8'h1C
`define PIU_ADDR_PERIPHERAL_IRQ_PRIORITY_2 8'h20
`define PIU_ADDR_RCC 8'h24
`define PIU_ADDR_T0CTL 8'h28
`define PIU_ADDR_T0LO 8'h2C
`define PIU_ADDR_T0HI 8'h30

// first control register bits
`define PIU_GIE 7
`define PIU_PERIPHERAL_IRQ_GATE 6
`define PIU_T0IE 5
`define PIU_X0IE 4
`define PIU_PORT_CHANGE_ENABLE 3
`define PIU_T0IF 2
`define PIU_X0IF 1
`define PIU_PORT_CHANGE_FLAG 0

// second control register bits
`define PIU_EDGE0 6
`define PIU_EDGE1 5
`define PIU_EDGE2 4
`define PIU_T0IP 2
`define PIU_PORT_CHANGE_PRIORITY 0

// third control register bits
`define PIU_X2IP 7
`define PIU_X1IP 6
`define PIU_X2IE 4
`define PIU_X1IE 3
`define PIU_X2IF 1
`define PIU_X1IF 0

// reset-cause register bits
`define PIU_PRIORITY_LEVELS_ON 7
`define PIU_RI 4
`define PIU_TO 3
`define PIU_PD 2
`define PIU_POR 1
`define PIU_BOR 0

// capture-compare one flag position in flag register 1
`define PIU_CC1 2

// timer-0 control bits
`define PIU_T0ON 7
`define PIU_T0_8BIT 6

// reset values
`define PIU_RST_INTCON 8'h00
`define PIU_RST_INTCON2 8'hF5
`define PIU_RST_THIRD_IRQ_CONTROL 8'hC0
`define PIU_RST_ZERO 8'h00
`define PIU_RST_PERIPHERAL_IRQ_PRIORITY_1 8'hFF
`define PIU_RST_PERIPHERAL_IRQ_PRIORITY_2 8'hDF
`define PIU_RST_RCC 8'h1C
`define PIU_RST_T0CTL 8'h40

// implemented-bit masks
`define PIU_MASK_INTCON2 8'hF5
`define PIU_MASK_THIRD_IRQ_CONTROL 8'hDB
`define PIU_MASK_REG2 8'hDF
`define PIU_MASK_RCC_WR 8'h93
`define PIU_MASK_T0CTL 8'hC0

// count limits
`define PIU_T0_MAX8 8'hFF
`define PIU_T0_MAX16 16'hFFFF
`define PIU_PC_W 21

`endif

/* hdl/piu_pin_sync.v */
// two-flop synchroniser with edge detection for a group of pins
// assumes the pins are asynchronous to clock_in; edges are masked until both
// the sync stage and the history stage hold real pin samples, so no false edge
// appears after reset whatever level the pins idle at
`timescale 1ns/10ps
module piu_pin_sync #(
  parameter W = 1
)
(
  input wire clock_in,
  input wire rst_in,
  input wire [W-1:0] pin_in,
  output wire [W-1:0] rise_out,
  output wire [W-1:0] fall_out
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;
  reg [W-1:0] last_ff;
  reg [2:0] primed_ff;

  // two-flop crossing, then one stage of history
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
      last_ff <= {W{1'b0}};
      primed_ff <= 3'h0;
    end
    else
    begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
      primed_ff <= {primed_ff[1:0], 1'b1}; // third edge: history holds a sample
    end
  end

  // edges only once history holds a real sample
  assign rise_out = (sync_ff & ~last_ff) & {W{primed_ff[2]}};
  assign fall_out = (~sync_ff & last_ff) & {W{primed_ff[2]}};

endmodule

/* hdl/piu_top.v */
// peripheral interrupt priority unit: enables, priorities, flags, reset cause,
// external pin and port-change interrupts, timer-0 overflow, context shadows
// assumes an apb master on clock_in; event and core inputs are single-cycle
// pulses on clock_in; pins are asynchronous and synchronised here
//
// Summary of operation
// - legacy mode: peripherals need gate plus enable
// - enable register one: eight peripheral enables, reset zero
// - enable register two: bit five reads zero
// - priority registers reset high, used when levels on
// - reset-cause bit seven switches priority levels
// - soft reset clears marker; firmware sets; bits six-five zero
// - watchdog flag: set power-up/clear/sleep, cleared on expiry
// - sleep marker: set power-up/clear, cleared by sleep
// - power-on flag cleared by power-on, firmware sets
// - brown-out flag cleared by brown-out, firmware sets
// - external pins: selectable edge sets pin flag
// - enabled pin interrupt wakes from power-managed mode
// - pins one, two priority bits; pin zero high
// - eight-bit timer wrap sets overflow flag
// - sixteen-bit pair wrap sets overflow flag
// - timer enable bit five, priority bit two
// - port upper nibble change sets change flag
// - interrupt entry pushes pc, copies shadow registers
// - capture or compare match sets capcomp one flag, except in pwm mode
// - flags set regardless of any enable
// - edge selects bits six-four, reset rising
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/10ps
`include "piu_consts.vh"
module piu_top
(
  input wire clock_in,
  input wire rst_in,
  // apb slave
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  // pins
  input wire [2:0] ext_pin_in,
  input wire [3:0] port_upper_in,
  // peripheral events
  input wire [7:0] periph1_event_in,
  input wire [7:0] periph2_event_in,
  input wire capcomp_capture_in,
  input wire capcomp_match_in,
  input wire capcomp_pwm_mode_in,
  input wire timer_zero_tick_in,
  // reset-cause events from the core
  input wire por_event_in,
  input wire bor_event_in,
  input wire soft_reset_event_in,
  input wire watchdog_expiry_in,
  input wire watchdog_clear_in,
  input wire sleep_exec_in,
  input wire power_managed_in,
  // core context at interrupt entry
  input wire irq_entry_in,
  input wire [20:0] core_pc_in,
  input wire [7:0] core_accum_in,
  input wire [7:0] core_status_in,
  input wire [7:0] core_bank_in,
  // core requests
  output reg irq_high_out,
  output reg irq_low_out,
  output reg wake_out,
  output reg stack_push_out,
  output reg [20:0] stack_pc_out,
  output reg [7:0] shadow_accum_out,
  output reg [7:0] shadow_status_out,
  output reg [7:0] shadow_bank_out
);

  reg [7:0] intcon_ff;
  reg [7:0] intcon2_ff;
  reg [7:0] third_irq_control_ff;
  reg [7:0] flag1_ff;
  reg [7:0] flag2_ff;
  reg [7:0] peripheral_irq_enable_1_ff;
  reg [7:0] peripheral_irq_enable_2_ff;
  reg [7:0] peripheral_irq_priority_1_ff;
  reg [7:0] peripheral_irq_priority_2_ff;
  reg [7:0] rcc_ff;
  reg [7:0] t0ctl_ff;
  reg [7:0] t0lo_ff;
  reg [7:0] t0hi_ff;
  reg [7:0] nxt_intcon;
  reg [7:0] nxt_third_irq_control;
  reg [7:0] nxt_flag1;
  reg [7:0] nxt_flag2;
  reg [7:0] nxt_rcc;
  reg [7:0] nxt_t0lo;
  reg [7:0] nxt_t0hi;
  reg [31:0] nxt_prdata;
  reg nxt_slverr;
  reg addr_hit;
  reg t0_wrap;
  wire [2:0] pin_rise;
  wire [2:0] pin_fall;
  wire [3:0] port_rise;
  wire [3:0] port_fall;
  wire [2:0] edge_sel;
  wire [2:0] pin_hit;
  wire port_change;
  wire wr_go;
  wire [7:0] wdat;
  wire [15:0] t0_pair;
  wire [7:0] act1;
  wire [7:0] act2;
  wire act_x0;
  wire act_x1;
  wire act_x2;
  wire act_t0;
  wire act_rb;
  wire core_any;
  wire periph_any;
  wire hi_any;
  wire lo_any;
  wire priority_levels_on;

  // pin synchronisers
  piu_pin_sync #(.W(3)) u_ext_sync
  (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .pin_in(ext_pin_in),
    .rise_out(pin_rise),
    .fall_out(pin_fall)
  );

  piu_pin_sync #(.W(4)) u_port_sync
  (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .pin_in(port_upper_in),
    .rise_out(port_rise),
    .fall_out(port_fall)
  );

  // edge choice per pin and change detect
  assign edge_sel = {intcon2_ff[`PIU_EDGE2], intcon2_ff[`PIU_EDGE1],
                     intcon2_ff[`PIU_EDGE0]};
  assign pin_hit = (edge_sel & pin_rise) | (~edge_sel & pin_fall);
  assign port_change = |(port_rise | port_fall);

  // apb write strobe: taken on the edge where pready is seen high
  assign wr_go = psel_in & penable_in & pready_out & pwrite_in;
  assign wdat = pwdata_in[7:0];
  assign t0_pair = {t0hi_ff, t0lo_ff};
  assign priority_levels_on = rcc_ff[`PIU_PRIORITY_LEVELS_ON];

  // timer-0 count and wrap detection
  always @*
  begin
    nxt_t0lo = t0lo_ff;
    nxt_t0hi = t0hi_ff;
    t0_wrap = 1'b0;
    if (t0ctl_ff[`PIU_T0ON] && timer_zero_tick_in)
    begin
      if (t0ctl_ff[`PIU_T0_8BIT])
      begin
        nxt_t0lo = t0lo_ff + 8'h01;
        t0_wrap = (t0lo_ff == `PIU_T0_MAX8);
      end
      else
      begin
        {nxt_t0hi, nxt_t0lo} = t0_pair + 16'h0001;
        t0_wrap = (t0_pair == `PIU_T0_MAX16);
      end
    end
    if (wr_go && paddr_in == `PIU_ADDR_T0LO)
      nxt_t0lo = wdat;
    if (wr_go && paddr_in == `PIU_ADDR_T0HI)
      nxt_t0hi = wdat;
  end

  // flag registers: software write, then hardware set wins
  always @*
  begin
    nxt_intcon = intcon_ff;
    nxt_third_irq_control = third_irq_control_ff;
    nxt_flag1 = flag1_ff;
    nxt_flag2 = flag2_ff;
    if (wr_go && paddr_in == `PIU_ADDR_INTCON)
      nxt_intcon = wdat;
    if (wr_go && paddr_in == `PIU_ADDR_THIRD_IRQ_CONTROL)
      nxt_third_irq_control = wdat & `PIU_MASK_THIRD_IRQ_CONTROL;
    if (wr_go && paddr_in == `PIU_ADDR_FLAG1)
      nxt_flag1 = wdat;
    if (wr_go && paddr_in == `PIU_ADDR_FLAG2)
      nxt_flag2 = wdat & `PIU_MASK_REG2;
    // sets ignore every enable so software can poll
    nxt_intcon[`PIU_X0IF] = nxt_intcon[`PIU_X0IF] | pin_hit[0];
    nxt_third_irq_control[`PIU_X1IF] = nxt_third_irq_control[`PIU_X1IF] | pin_hit[1];
    nxt_third_irq_control[`PIU_X2IF] = nxt_third_irq_control[`PIU_X2IF] | pin_hit[2];
    nxt_intcon[`PIU_T0IF] = nxt_intcon[`PIU_T0IF] | t0_wrap;
    nxt_intcon[`PIU_PORT_CHANGE_FLAG] = nxt_intcon[`PIU_PORT_CHANGE_FLAG] | port_change;
    nxt_flag1 = nxt_flag1 | periph1_event_in;
    nxt_flag1[`PIU_CC1] = nxt_flag1[`PIU_CC1] |
      ((capcomp_capture_in | capcomp_match_in) & ~capcomp_pwm_mode_in);
    nxt_flag2 = nxt_flag2 | (periph2_event_in & `PIU_MASK_REG2);
  end

  // reset-cause register: firmware write, then core events
  always @*
  begin
    nxt_rcc = rcc_ff;
    if (wr_go && paddr_in == `PIU_ADDR_RCC)
      nxt_rcc = (wdat & `PIU_MASK_RCC_WR) | (rcc_ff & ~`PIU_MASK_RCC_WR);
    if (watchdog_clear_in)
    begin
      nxt_rcc[`PIU_TO] = 1'b1;
      nxt_rcc[`PIU_PD] = 1'b1;
    end
    if (sleep_exec_in)
    begin
      nxt_rcc[`PIU_TO] = 1'b1;
      nxt_rcc[`PIU_PD] = 1'b0;
    end
    if (watchdog_expiry_in)
      nxt_rcc[`PIU_TO] = 1'b0;
    if (soft_reset_event_in)
      nxt_rcc[`PIU_RI] = 1'b0;
    if (bor_event_in)
      nxt_rcc[`PIU_BOR] = 1'b0;
    if (por_event_in)
    begin
      nxt_rcc[`PIU_POR] = 1'b0;
      nxt_rcc[`PIU_TO] = 1'b1;
      nxt_rcc[`PIU_PD] = 1'b1;
    end
  end

  // register state
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      intcon_ff <= `PIU_RST_INTCON;
      intcon2_ff <= `PIU_RST_INTCON2;
      third_irq_control_ff <= `PIU_RST_THIRD_IRQ_CONTROL;
      flag1_ff <= `PIU_RST_ZERO;
      flag2_ff <= `PIU_RST_ZERO;
      peripheral_irq_enable_1_ff <= `PIU_RST_ZERO;
      peripheral_irq_enable_2_ff <= `PIU_RST_ZERO;
      peripheral_irq_priority_1_ff <= `PIU_RST_PERIPHERAL_IRQ_PRIORITY_1;
      peripheral_irq_priority_2_ff <= `PIU_RST_PERIPHERAL_IRQ_PRIORITY_2;
      rcc_ff <= `PIU_RST_RCC;
      t0ctl_ff <= `PIU_RST_T0CTL;
      t0lo_ff <= `PIU_RST_ZERO;
      t0hi_ff <= `PIU_RST_ZERO;
    end
    else
    begin
      intcon_ff <= nxt_intcon;
      third_irq_control_ff <= nxt_third_irq_control;
      flag1_ff <= nxt_flag1;
      flag2_ff <= nxt_flag2;
      rcc_ff <= nxt_rcc;
      t0lo_ff <= nxt_t0lo;
      t0hi_ff <= nxt_t0hi;
      if (wr_go && paddr_in == `PIU_ADDR_INTCON2)
        intcon2_ff <= wdat & `PIU_MASK_INTCON2;
      if (wr_go && paddr_in == `PIU_ADDR_PERIPHERAL_IRQ_ENABLE_1)
        peripheral_irq_enable_1_ff <= wdat;
      if (wr_go && paddr_in == `PIU_ADDR_PERIPHERAL_IRQ_ENABLE_2)
        peripheral_irq_enable_2_ff <= wdat & `PIU_MASK_REG2;
      if (wr_go && paddr_in == `PIU_ADDR_PERIPHERAL_IRQ_PRIORITY_1)
        peripheral_irq_priority_1_ff <= wdat;
      if (wr_go && paddr_in == `PIU_ADDR_PERIPHERAL_IRQ_PRIORITY_2)
        peripheral_irq_priority_2_ff <= wdat & `PIU_MASK_REG2;
      if (wr_go && paddr_in == `PIU_ADDR_T0CTL)
        t0ctl_ff <= wdat & `PIU_MASK_T0CTL;
    end
  end

  // read mux and unmapped-address detect
  always @*
  begin
    nxt_prdata = 32'h0000_0000;
    addr_hit = 1'b1;
    case (paddr_in)
      `PIU_ADDR_INTCON: nxt_prdata[7:0] = intcon_ff;
      `PIU_ADDR_INTCON2: nxt_prdata[7:0] = intcon2_ff;
      `PIU_ADDR_THIRD_IRQ_CONTROL: nxt_prdata[7:0] = third_irq_control_ff;
      `PIU_ADDR_FLAG1: nxt_prdata[7:0] = flag1_ff;
      `PIU_ADDR_FLAG2: nxt_prdata[7:0] = flag2_ff;
      `PIU_ADDR_PERIPHERAL_IRQ_ENABLE_1: nxt_prdata[7:0] = peripheral_irq_enable_1_ff;
      `PIU_ADDR_PERIPHERAL_IRQ_ENABLE_2: nxt_prdata[7:0] = peripheral_irq_enable_2_ff;
      `PIU_ADDR_PERIPHERAL_IRQ_PRIORITY_1: nxt_prdata[7:0] = peripheral_irq_priority_1_ff;
      `PIU_ADDR_PERIPHERAL_IRQ_PRIORITY_2: nxt_prdata[7:0] = peripheral_irq_priority_2_ff;
      `PIU_ADDR_RCC: nxt_prdata[7:0] = rcc_ff;
      `PIU_ADDR_T0CTL: nxt_prdata[7:0] = t0ctl_ff;
      `PIU_ADDR_T0LO: nxt_prdata[7:0] = t0lo_ff;
      `PIU_ADDR_T0HI: nxt_prdata[7:0] = t0hi_ff;
      default: addr_hit = 1'b0;
    endcase
    nxt_slverr = ~addr_hit;
  end

  // apb answer: one wait state, pready raised in the second access cycle
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end
    else
    begin
      pready_out <= psel_in & penable_in & ~pready_out;
      if (psel_in && penable_in && !pready_out)
      begin
        prdata_out <= pwrite_in ? 32'h0000_0000 : nxt_prdata;
        pslverr_out <= nxt_slverr;
      end
      else
      begin
        prdata_out <= 32'h0000_0000;
        pslverr_out <= 1'b0;
      end
    end
  end

  // active sources: flag and its own enable
  assign act1 = flag1_ff & peripheral_irq_enable_1_ff;
  assign act2 = flag2_ff & peripheral_irq_enable_2_ff & `PIU_MASK_REG2;
  assign act_x0 = intcon_ff[`PIU_X0IF] & intcon_ff[`PIU_X0IE];
  assign act_x1 = third_irq_control_ff[`PIU_X1IF] & third_irq_control_ff[`PIU_X1IE];
  assign act_x2 = third_irq_control_ff[`PIU_X2IF] & third_irq_control_ff[`PIU_X2IE];
  assign act_t0 = intcon_ff[`PIU_T0IF] & intcon_ff[`PIU_T0IE];
  assign act_rb = intcon_ff[`PIU_PORT_CHANGE_FLAG] & intcon_ff[`PIU_PORT_CHANGE_ENABLE];
  assign core_any = act_x0 | act_x1 | act_x2 | act_t0 | act_rb;
  assign periph_any = |act1 | |act2;

  // split by priority; pin zero is always high
  assign hi_any = act_x0 | (act_x1 & third_irq_control_ff[`PIU_X1IP]) |
    (act_x2 & third_irq_control_ff[`PIU_X2IP]) | (act_t0 & intcon2_ff[`PIU_T0IP]) |
    (act_rb & intcon2_ff[`PIU_PORT_CHANGE_PRIORITY]) | |(act1 & peripheral_irq_priority_1_ff) |
    |(act2 & peripheral_irq_priority_2_ff);
  assign lo_any = (act_x1 & ~third_irq_control_ff[`PIU_X1IP]) |
    (act_x2 & ~third_irq_control_ff[`PIU_X2IP]) | (act_t0 & ~intcon2_ff[`PIU_T0IP]) |
    (act_rb & ~intcon2_ff[`PIU_PORT_CHANGE_PRIORITY]) | |(act1 & ~peripheral_irq_priority_1_ff) |
    |(act2 & ~peripheral_irq_priority_2_ff);

  // requests to the core, wake and context capture
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      irq_high_out <= 1'b0;
      irq_low_out <= 1'b0;
      wake_out <= 1'b0;
      stack_push_out <= 1'b0;
      stack_pc_out <= 21'h00_0000;
      shadow_accum_out <= 8'h00;
      shadow_status_out <= 8'h00;
      shadow_bank_out <= 8'h00;
    end
    else
    begin
      if (priority_levels_on)
      begin
        irq_high_out <= intcon_ff[`PIU_GIE] & hi_any;
        irq_low_out <= intcon_ff[`PIU_PERIPHERAL_IRQ_GATE] & lo_any;
      end
      else
      begin
        // single level: peripherals also need the gate bit
        irq_high_out <= intcon_ff[`PIU_GIE] &
          (core_any | (intcon_ff[`PIU_PERIPHERAL_IRQ_GATE] & periph_any));
        irq_low_out <= 1'b0;
      end
      wake_out <= power_managed_in & (act_x0 | act_x1 | act_x2);
      stack_push_out <= irq_entry_in;
      if (irq_entry_in)
      begin
        stack_pc_out <= core_pc_in;
        shadow_accum_out <= core_accum_in;
        shadow_status_out <= core_status_in;
        shadow_bank_out <= core_bank_in;
      end
    end
  end

endmodule

/* verification/piu_core_model.sv */
// core-side partner: vectors once on each new request, offers moving context
// assumes the request levels of piu_top on the same clock
`timescale 1ns/10ps
module piu_core_model
(
  input wire clock_in,
  input wire rst_in,
  input wire irq_high_in,
  input wire irq_low_in,
  output reg irq_entry_out,
  output reg [20:0] pc_out,
  output reg [7:0] accum_out,
  output reg [7:0] status_out,
  output reg [7:0] bank_out
);
  reg req_ff;
  // one entry per rising request; context words change every cycle
  always @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      req_ff <= 1'b0;
      irq_entry_out <= 1'b0;
      {pc_out, accum_out, status_out, bank_out} <= 45'h0;
    end
    else
    begin
      req_ff <= irq_high_in | irq_low_in;
      irq_entry_out <= (irq_high_in | irq_low_in) & ~req_ff;
      pc_out <= pc_out + 21'h00007;
      accum_out <= accum_out + 8'h03;
      status_out <= ~status_out;
      bank_out <= bank_out + 8'h0D;
    end
  end
endmodule

/* verification/piu_top_sva.sv */
// checker for piu_top: apb answer timing, idle read data, entry context, wake
// assumes it is bound to piu_top and sees its ports only
`timescale 1ns/10ps
module piu_top_sva
(
  input wire clock_in,
  input wire rst_in,
  input wire psel_in,
  input wire penable_in,
  input wire [31:0] prdata_out,
  input wire pready_out,
  input wire pslverr_out,
  input wire power_managed_in,
  input wire irq_entry_in,
  input wire [20:0] core_pc_in,
  input wire [7:0] core_accum_in,
  input wire [7:0] core_bank_in,
  input wire wake_out,
  input wire stack_push_out,
  input wire [20:0] stack_pc_out,
  input wire [7:0] shadow_accum_out,
  input wire [7:0] shadow_bank_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  // entry followed by its push
  sequence s_entry;
    irq_entry_in ##1 stack_push_out;
  endsequence
  // setup then one idle access cycle then the answer
  sequence s_answer;
    !pready_out ##1 pready_out;
  endsequence
  AST_ENTRY_PUSH: assert property (irq_entry_in |=> stack_push_out)
    else $error("no push after entry");
  AST_ENTRY_COPY: assert property (s_entry |-> stack_pc_out == $past(core_pc_in)
    && shadow_accum_out == $past(core_accum_in) && shadow_bank_out == $past(core_bank_in))
    else $error("context not copied");
  AST_PUSH_CAUSE: assert property (stack_push_out |-> $past(irq_entry_in))
    else $error("push without entry");
  AST_SHADOW_HOLD: assert property (!$past(irq_entry_in) |-> $stable(stack_pc_out)
    && $stable(shadow_accum_out))
    else $error("shadow changed without entry");
  AST_WAKE_CAUSE: assert property ($rose(wake_out) |-> $past(power_managed_in))
    else $error("wake outside power-managed mode");
  AST_ANSWER_TIME: assert property (psel_in && !penable_in |=> s_answer)
    else $error("answer not on second access edge");
  AST_READY_ONE: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  AST_READY_CAUSE: assert property (pready_out |-> psel_in && penable_in)
    else $error("ready without access");
  AST_ERR_READY: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  AST_RDATA_IDLE: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("read data outside answer");
  AST_UPPER_ZERO: assert property (prdata_out[31:8] == 24'h0)
    else $error("upper read data not zero");
endmodule

bind piu_top piu_top_sva i_piu_top_sva(.clock_in, .rst_in, .psel_in, .penable_in,
  .prdata_out, .pready_out, .pslverr_out, .power_managed_in, .irq_entry_in, .core_pc_in,
  .core_accum_in, .core_bank_in, .wake_out, .stack_push_out, .stack_pc_out,
  .shadow_accum_out, .shadow_bank_out);

/* verification/test_peripheral_interrupt_priority_unit.sv */
// bench for piu_top: registers, reset cause, events, pins, timer, entry
// assumes piu_top and piu_core_model; reads and entries checked from queues
`timescale 1ns/10ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, a); end end
module test_peripheral_interrupt_priority_unit;
  reg clock_in = 1'b0, rst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  reg [7:0] paddr_in = 8'h00, periph1_event_in = 8'h00, periph2_event_in = 8'h00, rv;
  reg [31:0] pwdata_in = 32'h0;
  reg [2:0] ext_pin_in = 3'h0;
  reg [3:0] port_upper_in = 4'h0;
  reg [5:0] core_ev = 6'h00;
  reg capcomp_capture_in = 0, capcomp_match_in = 0, capcomp_pwm_mode_in = 0;
  reg timer_zero_tick_in = 0, power_managed_in = 0;
  wire por_event_in = core_ev[0], bor_event_in = core_ev[1], soft_reset_event_in = core_ev[2];
  wire watchdog_expiry_in = core_ev[3], watchdog_clear_in = core_ev[4];
  wire sleep_exec_in = core_ev[5];
  wire irq_entry_in, irq_high_out, irq_low_out, wake_out, stack_push_out, pready_out;
  wire pslverr_out;
  wire [20:0] core_pc_in, stack_pc_out;
  wire [7:0] core_accum_in, core_status_in, core_bank_in;
  wire [7:0] shadow_accum_out, shadow_status_out, shadow_bank_out;
  wire [31:0] prdata_out;
  integer bad_count = 0, cmp_count = 0, seed = 32'hd1077921, i;
  reg [32:0] rd_q[$];
  reg [32:0] re;
  reg [44:0] ctx_q[$];
  reg [44:0] ce;
  reg [7:0] rst_tab [0:12] = '{8'h00, 8'hF5, 8'hC0, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF,
    8'hDF, 8'h1C, 8'h40, 8'h00, 8'h00};
  piu_top i_piu_top(.clock_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .ext_pin_in, .port_upper_in,
    .periph1_event_in, .periph2_event_in, .capcomp_capture_in, .capcomp_match_in,
    .capcomp_pwm_mode_in, .timer_zero_tick_in, .por_event_in, .bor_event_in,
    .soft_reset_event_in, .watchdog_expiry_in, .watchdog_clear_in, .sleep_exec_in,
    .power_managed_in, .irq_entry_in, .core_pc_in, .core_accum_in, .core_status_in,
    .core_bank_in, .irq_high_out, .irq_low_out, .wake_out, .stack_push_out, .stack_pc_out,
    .shadow_accum_out, .shadow_status_out, .shadow_bank_out);
  piu_core_model i_piu_core_model(.clock_in, .rst_in, .irq_high_in(irq_high_out),
    .irq_low_in(irq_low_out), .irq_entry_out(irq_entry_in), .pc_out(core_pc_in),
    .accum_out(core_accum_in), .status_out(core_status_in), .bank_out(core_bank_in));
  always #20 clock_in = ~clock_in;
  // results taken off the queues as they appear
  always @(posedge clock_in)
  begin
    if (irq_entry_in)
      ctx_q.push_back({core_pc_in, core_accum_in, core_status_in, core_bank_in});
    if (stack_push_out && ctx_q.size() > 0)
    begin
      ce = ctx_q.pop_front();
      re = 33'h0;
      `CHK("context", ce, {stack_pc_out, shadow_accum_out, shadow_status_out,
        shadow_bank_out})
    end
    if (pready_out && psel_in && !pwrite_in && rd_q.size() > 0)
    begin
      re = rd_q.pop_front();
      `CHK("read", re, {pslverr_out, prdata_out})
    end
  end
  task print_verdict;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task tick(input integer c);
    repeat (c) @(posedge clock_in);
  endtask
  // one apb transfer; a read notes its expected answer first
  task apb(input w, input [7:0] a, input [7:0] d, input [32:0] exp);
    integer n;
    begin
      n = 0;
      if (!w)
        rd_q.push_back(exp);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= {24'h0, d};
      tick(1);
      penable_in <= 1'b1;
      tick(1);
      while (pready_out !== 1'b1 && n < 20) @(posedge clock_in) n = n + 1;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      tick(1);
      if (n >= 20)
      begin
        bad_count++;
        $display("[FAIL] pready exp 1 got 0");
        print_verdict;
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task rd(input [7:0] a, input [7:0] d);
    apb(1'b0, a, 8'h00, {25'h0, d});
  endtask
  task pulse(input [5:0] v);
    begin
      core_ev <= v;
      tick(1);
      core_ev <= 6'h00;
    end
  endtask
  task irq(input [1:0] e);
    begin
      tick(3);
      `CHK("irq", e, {irq_low_out, irq_high_out})
    end
  endtask
  // main sequence
  initial
  begin
    tick(16);
    rst_in <= 1'b0;
    for (i = 0; i < 13; i++) rd(i * 4, rst_tab[i]);
    apb(1'b0, 8'h34, 8'h00, {1'b1, 32'h0});
    apb(1'b1, 8'h34, 8'hFF, 33'h0);
    rv = $random(seed);
    wr(8'h14, rv & 8'h7F);
    rd(8'h14, rv & 8'h7F);
    wr(8'h20, rv);
    rd(8'h20, rv & 8'hDF);
    wr(8'h18, 8'hFF);
    rd(8'h18, 8'hDF);
    wr(8'h24, 8'hFF);
    rd(8'h24, 8'h9F);
    pulse(6'h20);
    rd(8'h24, 8'h9B);
    pulse(6'h08);
    rd(8'h24, 8'h93);
    pulse(6'h10);
    rd(8'h24, 8'h9F);
    pulse(6'h04);
    rd(8'h24, 8'h8F);
    pulse(6'h02);
    rd(8'h24, 8'h8E);
    wr(8'h24, 8'h00);
    wr(8'h14, 8'h01);
    wr(8'h00, 8'h80);
    periph1_event_in <= 8'h01;
    tick(1);
    periph1_event_in <= 8'h00;
    irq(2'b00);
    rd(8'h0C, 8'h01);
    wr(8'h00, 8'hC0);
    irq(2'b01);
    wr(8'h24, 8'h80);
    wr(8'h1C, 8'hFE);
    irq(2'b10);
    wr(8'h1C, 8'hFF);
    irq(2'b01);
    wr(8'h0C, 8'h00);
    irq(2'b00);
    wr(8'h00, 8'h00);
    ext_pin_in <= 3'h7;
    tick(6);
    rd(8'h00, 8'h02);
    rd(8'h08, 8'hC3);
    wr(8'h04, 8'h85);
    wr(8'h00, 8'h10);
    wr(8'h08, 8'hC0);
    power_managed_in <= 1'b1;
    ext_pin_in <= 3'h0;
    tick(6);
    `CHK("wake", 1'b1, wake_out)
    rd(8'h00, 8'h12);
    rd(8'h08, 8'hC3);
    power_managed_in <= 1'b0;
    wr(8'h08, 8'h09);
    wr(8'h00, 8'h40);
    irq(2'b10);
    wr(8'h00, 8'h92);
    irq(2'b01);
    wr(8'h00, 8'h00);
    wr(8'h28, 8'hC0);
    wr(8'h2C, 8'hFE);
    timer_zero_tick_in <= 1'b1;
    tick(2);
    timer_zero_tick_in <= 1'b0;
    rd(8'h00, 8'h04);
    rd(8'h2C, 8'h00);
    wr(8'h00, 8'h00);
    wr(8'h28, 8'h80);
    wr(8'h30, 8'hFF);
    wr(8'h2C, 8'hFF);
    timer_zero_tick_in <= 1'b1;
    tick(1);
    timer_zero_tick_in <= 1'b0;
    rd(8'h00, 8'h04);
    rd(8'h30, 8'h00);
    wr(8'h00, 8'h00);
    port_upper_in <= 4'h8;
    tick(6);
    rd(8'h00, 8'h01);
    wr(8'h0C, 8'h00);
    capcomp_pwm_mode_in <= 1'b1;
    capcomp_capture_in <= 1'b1;
    tick(1);
    capcomp_capture_in <= 1'b0;
    rd(8'h0C, 8'h00);
    capcomp_pwm_mode_in <= 1'b0;
    capcomp_match_in <= 1'b1;
    tick(1);
    capcomp_match_in <= 1'b0;
    rd(8'h0C, 8'h04);
    periph2_event_in <= 8'hFF;
    tick(1);
    periph2_event_in <= 8'h00;
    rd(8'h10, 8'hDF);
    tick(4);
    print_verdict;
  end
endmodule
